// *** include/lsc_defs.vh ***
// Constants shared by the segment command and refresh logic
`ifndef LSC_DEFS_VH
`define LSC_DEFS_VH

// Register byte offsets on the AHB-Lite slave
`define LSC_CTRL_OFS 8'h00
`define LSC_STATUS_OFS 8'h04
`define LSC_ROWCNT_OFS 8'h08

// Control register fields
`define LSC_CTRL_REFRESH_EN 0
`define LSC_CTRL_POL_EN 1
`define LSC_CTRL_RESET 32'h00000003

// Status register fields
`define LSC_STAT_SCROLL_LSB 0
`define LSC_STAT_UPPER 8
`define LSC_STAT_A_IN 9
`define LSC_STAT_PEND 10

// Command qualifier codes {high, low}
`define LSC_CMD_ROW_WRITE 2'b00
`define LSC_CMD_ROW_READ 2'b01
`define LSC_CMD_SCROLL 2'b10
`define LSC_CMD_CONTROL 2'b11

// Control command bit positions
`define LSC_CBIT_RESET 0
`define LSC_CBIT_UPPER 1
`define LSC_CBIT_CLEAR_SHIFT_REG 2

// Reset values
`define LSC_SCROLL_RESET 7'h00
`define LSC_UPPER_RESET 1'b0

`endif

// *** logic/lsc_ctrl.v ***
// Segment driver command interpreter, shift register and refresh logic
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.vh"

//Behaviour
// - capture command, execute next bus clock
// - both qualifiers low: shift register to row
// - qualifier low only: row to shift register
// - qualifier high only: add offset to scroll
// - scroll vector presets refresh row counter
// - control bit0 clears the scroll vector
// - control bit1 stores upper panel, swaps lines
// - control bit2 clears the shift register
// - latch filled row by row from scroll
// - latch holds one row, drives segments
// - RAM 160x80, changed only by row transfers
// - 160-bit shift register, shifts both ways
// - data sampled on falling shift clock edge
// - direction xor upper panel picks input line
// - display off floats all segment outputs
// - commands accepted only with chip select low
module lsc_ctrl #(
	parameter WIDTH = 160,
	parameter ROWS = 80,
	parameter AW = 7
) (
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Host command port
	input wire host_bus_clock,
	input wire command_strobe,
	input wire chip_select_n,
	input wire cmd_qualifier_low,
	input wire cmd_qualifier_high,
	input wire [6:0] command_bus,
	// Serial data port
	input wire serial_shift_clock,
	input wire serial_direction,
	input wire serial_line_a_i,
	output wire serial_line_a_o,
	output wire serial_line_a_oe,
	input wire serial_line_b_i,
	output wire serial_line_b_o,
	output wire serial_line_b_oe,
	// Refresh timing
	input wire refresh_clock,
	input wire frame_sync,
	input wire sync_phase,
	input wire display_off,
	// Segment drive
	output reg [WIDTH-1:0] segment_outputs,
	output wire segment_outputs_oe,
	output wire upper_panel_select
);

	// Wrap a row number into the RAM row range
	function [AW-1:0] row_wrap;
		input [AW:0] val;
		reg [AW:0] t;
		begin
			t = val;
			if (t >= ROWS) begin
				t = t - ROWS[AW:0];
			end
			if (t >= ROWS) begin
				t = t - ROWS[AW:0];
			end
			row_wrap = t[AW-1:0];
		end
	endfunction

	// Pin synchroniser, two flops, then one more stage for edge detection
	localparam NPIN = 20;
	wire [NPIN-1:0] pins_raw;
	reg [NPIN-1:0] sync1_q; // First stage, read only by sync2_q
	reg [NPIN-1:0] sync2_q; // Safe synchronised levels
	reg [NPIN-1:0] sync3_q; // Previous level, for edges

	assign pins_raw = {host_bus_clock, command_strobe, chip_select_n, cmd_qualifier_low,
		cmd_qualifier_high, command_bus, serial_shift_clock, serial_direction,
		serial_line_a_i, serial_line_b_i, refresh_clock, frame_sync, sync_phase,
		display_off};

	// Every pin is asynchronous to hclk
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= {NPIN{1'b0}};
			sync2_q <= {NPIN{1'b0}};
			sync3_q <= {NPIN{1'b0}};
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Named views of the synchronised pins
	wire bclk_s = sync2_q[19];
	wire strobe_s = sync2_q[18];
	wire cs_n_s = sync2_q[17];
	wire ql_s = sync2_q[16];
	wire qh_s = sync2_q[15];
	wire [6:0] cbus_s = sync2_q[14:8];
	wire serial_shift_clock_s = sync2_q[7];
	wire dir_s = sync2_q[6];
	wire a_in_s = sync2_q[5];
	wire b_in_s = sync2_q[4];
	wire rclk_s = sync2_q[3];
	wire frame_s = sync2_q[2];
	wire phase_s = sync2_q[1];
	wire display_off_s = sync2_q[0];

	// Edge detectors on the synchronised levels
	wire bclk_rise = bclk_s & ~sync3_q[19];
	wire serial_shift_clock_fall = ~serial_shift_clock_s & sync3_q[7];
	wire rclk_rise = rclk_s & ~sync3_q[3];
	wire frame_rise = frame_s & ~sync3_q[2];

	// AHB-Lite slave state
	reg [31:0] ctrl_q; // Control register
	reg wr_pend_q; // Write data phase pending
	reg [7:0] wr_ofs_q; // Offset of pending write
	wire ahb_sel = hsel & htrans[1] & hready;

	// Command state
	reg [8:0] cmd_q; // {high, low, bus} captured command
	reg cmd_pend_q; // Waiting for next bus clock
	reg [AW-1:0] scroll_q; // Vertical scroll vector
	reg upper_q; // Upper panel setting
	reg [WIDTH-1:0] shreg_q; // Serial shift register

	// Refresh state
	reg [AW-1:0] row_cnt_q; // Presettable refresh row counter
	reg ref_pend_q; // Refresh row read waiting for RAM
	reg [AW-1:0] ref_addr_q; // Row to fetch for the latch
	reg [WIDTH-1:0] latch_q; // Display data latch array
	reg rd_cmd_q; // RAM data next cycle goes to shift register
	reg rd_ref_q; // RAM data next cycle goes to latch

	// Execution happens at the bus clock rise after capture
	wire exec = cmd_pend_q & bclk_rise;
	wire [1:0] cmd_kind = cmd_q[8:7];
	wire [AW-1:0] cmd_row = cmd_q[AW-1:0];
	wire row_ok = (cmd_q[6:0] < ROWS); // Out-of-range rows are ignored
	wire do_wr = exec && (cmd_kind == `LSC_CMD_ROW_WRITE) && row_ok;
	wire do_rd = exec && (cmd_kind == `LSC_CMD_ROW_READ) && row_ok;
	wire do_ctl = exec && (cmd_kind == `LSC_CMD_CONTROL);

	// RAM port: host transfers win, refresh waits one cycle at most
	wire ref_go = ref_pend_q & ~do_wr & ~do_rd;
	wire ram_en = do_wr | do_rd | ref_go;
	wire [AW-1:0] ram_addr = (do_wr | do_rd) ? cmd_row : ref_addr_q;
	wire [WIDTH-1:0] ram_rdata;

	// Row transfers are the only path into the RAM
	lsc_row_ram #(
		.WIDTH(WIDTH),
		.ROWS(ROWS),
		.AW(AW)
	) u_ram (
		.clk(hclk),
		.en(ram_en),
		.we(do_wr),
		.addr(ram_addr),
		.wdata(shreg_q),
		.rdata(ram_rdata)
	);

	// Command capture: strobe with chip select low on a bus clock rise
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= 9'h000;
			cmd_pend_q <= 1'b0;
		end else begin
			if (bclk_rise && strobe_s && !cs_n_s) begin
				// New capture wins over the execution that clears pending
				cmd_q <= {qh_s, ql_s, cbus_s};
				cmd_pend_q <= 1'b1;
			end else if (exec) begin
				cmd_pend_q <= 1'b0;
			end
		end
	end

	// Scroll vector and upper panel setting
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scroll_q <= `LSC_SCROLL_RESET;
			upper_q <= `LSC_UPPER_RESET;
		end else if (exec) begin
			case (cmd_kind)
				`LSC_CMD_SCROLL: begin
					// Offset added to old vector, wrapped into row range
					scroll_q <= row_wrap({1'b0, scroll_q} + {1'b0, cmd_q[6:0]});
				end
				`LSC_CMD_CONTROL: begin
					// Bits 6..3 carry nothing here
					if (cmd_q[`LSC_CBIT_RESET]) begin
						scroll_q <= `LSC_SCROLL_RESET;
					end
					upper_q <= cmd_q[`LSC_CBIT_UPPER];
				end
				default: begin
					scroll_q <= scroll_q;
				end
			endcase
		end
	end

	// Line A is the input when direction and upper panel differ
	wire a_is_input = dir_s ^ upper_q;

	// Shift register: RAM load, then clear, then serial shift
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shreg_q <= {WIDTH{1'b0}};
		end else if (rd_cmd_q) begin
			shreg_q <= ram_rdata;
		end else if (do_ctl && cmd_q[`LSC_CBIT_CLEAR_SHIFT_REG]) begin
			shreg_q <= {WIDTH{1'b0}};
		end else if (serial_shift_clock_fall) begin
			// Sample on the falling shift clock edge
			if (a_is_input) begin
				shreg_q <= {shreg_q[WIDTH-2:0], a_in_s};
			end else begin
				shreg_q <= {b_in_s, shreg_q[WIDTH-1:1]};
			end
		end
	end

	// Serial outputs: the far end of the register, on the output line only
	assign serial_line_b_o = shreg_q[WIDTH-1];
	assign serial_line_a_o = shreg_q[0];
	assign serial_line_b_oe = a_is_input;
	assign serial_line_a_oe = ~a_is_input;
	assign upper_panel_select = upper_q;

	// Refresh: frame preset from scroll vector, refresh clock steps rows
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			row_cnt_q <= `LSC_SCROLL_RESET;
			ref_pend_q <= 1'b0;
			ref_addr_q <= `LSC_SCROLL_RESET;
		end else begin
			if (frame_rise) begin
				// Frame start reloads the counter from the vector
				row_cnt_q <= scroll_q;
			end else if (rclk_rise && ctrl_q[`LSC_CTRL_REFRESH_EN]) begin
				row_cnt_q <= row_wrap({1'b0, row_cnt_q} + 8'h01);
			end
			if (rclk_rise && ctrl_q[`LSC_CTRL_REFRESH_EN]) begin
				// A new request wins over the grant of an older one
				ref_pend_q <= 1'b1;
				ref_addr_q <= frame_rise ? scroll_q : row_cnt_q;
			end else if (ref_go) begin
				ref_pend_q <= 1'b0;
			end
		end
	end

	// Steer the registered RAM data to its consumer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_cmd_q <= 1'b0;
			rd_ref_q <= 1'b0;
		end else begin
			rd_cmd_q <= do_rd;
			rd_ref_q <= ref_go;
		end
	end

	// Display latch: one whole row at a time
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_q <= {WIDTH{1'b0}};
		end else if (rd_ref_q) begin
			latch_q <= ram_rdata;
		end
	end

	// Segment data; optional polarity flip on the sync phase for AC drive
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			segment_outputs <= {WIDTH{1'b0}};
		end else begin
			segment_outputs <= latch_q ^ {WIDTH{phase_s & ctrl_q[`LSC_CTRL_POL_EN]}};
		end
	end

	// All segments float while the display is off
	assign segment_outputs_oe = ~display_off_s;

	// AHB-Lite: always ready, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Status word built from live block state
	wire [31:0] status_word = {21'h00000, cmd_pend_q, a_is_input, upper_q, 1'b0, scroll_q};

	// Address phase: read data registered for the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 8'h00;
		end else begin
			wr_pend_q <= ahb_sel & hwrite;
			wr_ofs_q <= haddr[7:0];
			if (ahb_sel && !hwrite) begin
				case (haddr[7:0])
					`LSC_CTRL_OFS: hrdata <= ctrl_q;
					`LSC_STATUS_OFS: hrdata <= status_word;
					`LSC_ROWCNT_OFS: hrdata <= {25'h000000, row_cnt_q};
					default: hrdata <= 32'h00000000; // Unmapped reads as zero
				endcase
			end
		end
	end

	// Data phase write: only the control register is writable
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `LSC_CTRL_RESET;
		end else if (wr_pend_q && (wr_ofs_q == `LSC_CTRL_OFS)) begin
			ctrl_q <= {30'h0000000, hwdata[1:0]};
		end
	end

	// Unused bus attributes: only whole-word transfers are expected
	wire unused_ok = &{1'b0, hsize, haddr[31:8]};

endmodule

`default_nettype wire

// *** logic/lsc_row_ram.v ***
// Display RAM: one row per access, registered read data
`timescale 1ns/1ps
`default_nettype none

module lsc_row_ram #(
	parameter WIDTH = 160,
	parameter ROWS = 80,
	parameter AW = 7
) (
	input wire clk,
	input wire en,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [WIDTH-1:0] wdata,
	output reg [WIDTH-1:0] rdata
);

	// Row storage; no reset, as with real SRAM
	reg [WIDTH-1:0] mem [0:ROWS-1];

	// Single port: write or read one whole row per cycle
	always @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
		if (en && !we) begin
			rdata <= mem[addr];
		end
	end

endmodule

`default_nettype wire

// *** tb/lsc_ctrl_chk.sv ***
// Port checker for the segment command and refresh logic
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic host_bus_clock,
	input wire logic serial_shift_clock,
	input wire logic serial_direction,
	input wire logic serial_line_a_o,
	input wire logic serial_line_a_oe,
	input wire logic serial_line_b_o,
	input wire logic serial_line_b_oe,
	input wire logic display_off,
	input wire logic segment_outputs_oe,
	input wire logic upper_panel_select
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read address phase accepted by the slave
	wire logic rd = hsel && htrans[1] && !hwrite;
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stall or error");
	one_driver_a: assert property (serial_line_a_oe ^ serial_line_b_oe)
		else $error("line enables clash");
	line_dir_a: assert property (($stable(serial_direction) &&
		$stable(upper_panel_select))[*6] |-> serial_line_a_oe == !(serial_direction ^
		upper_panel_select)) else $error("wrong input line");
	seg_float_a: assert property ($stable(display_off)[*5] |->
		segment_outputs_oe == !display_off) else $error("segment enable wrong");
	upper_hold_a: assert property ((!host_bus_clock)[*8] |-> $stable(upper_panel_select))
		else $error("panel bit moved without command");
	shift_quiet_a: assert property ((serial_shift_clock && !host_bus_clock)[*8] |->
		$stable(serial_line_a_o) && $stable(serial_line_b_o)) else $error("shift without edge");
	unmapped_a: assert property (rd && haddr == 32'h10 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	status_a: assert property (rd && haddr == 32'h4 |=> hrdata[6:0] < 7'd80 &&
		hrdata[8] == $past(upper_panel_select) && hrdata[9] == !$past(serial_line_a_oe))
		else $error("status mismatch");
	rowcnt_a: assert property (rd && haddr == 32'h8 |=> hrdata[6:0] < 7'd80)
		else $error("row counter out of range");
endmodule
bind lsc_ctrl lsc_ctrl_chk u_lsc_ctrl_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hreadyout, .hresp, .hrdata, .host_bus_clock, .serial_shift_clock, .serial_direction,
	.serial_line_a_o, .serial_line_a_oe, .serial_line_b_o, .serial_line_b_oe, .display_off,
	.segment_outputs_oe, .upper_panel_select);
`default_nettype wire

// *** tb/lsc_ctrl_test.sv ***
// Self-checking bench for the segment command and refresh logic
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_test;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic serial_direction = 1'b0, refresh_clock = 1'b0, frame_sync = 1'b0;
	logic sync_phase = 1'b0, display_off = 1'b0;
	wire logic hreadyout, hresp, host_bus_clock, command_strobe, chip_select_n;
	wire logic cmd_qualifier_low, cmd_qualifier_high, serial_shift_clock, segment_outputs_oe;
	wire logic serial_line_a_i, serial_line_a_o, serial_line_a_oe, upper_panel_select;
	wire logic serial_line_b_i, serial_line_b_o, serial_line_b_oe;
	wire logic [6:0] command_bus;
	wire logic [31:0] hrdata;
	wire logic [159:0] segment_outputs;
	logic [159:0] row_v;
	logic [6:0] vec, off, row;
	int bad_count = 0, samples_checked = 0;
	always #25 hclk = ~hclk;
	lsc_ctrl u_lsc_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .host_bus_clock, .command_strobe,
		.chip_select_n, .cmd_qualifier_low, .cmd_qualifier_high, .command_bus,
		.serial_shift_clock, .serial_direction, .serial_line_a_i, .serial_line_a_o,
		.serial_line_a_oe, .serial_line_b_i, .serial_line_b_o, .serial_line_b_oe, .refresh_clock,
		.frame_sync, .sync_phase, .display_off, .segment_outputs, .segment_outputs_oe,
		.upper_panel_select);
	lsc_host_model u_lsc_host_model (.hclk, .serial_line_a_o, .serial_line_a_oe,
		.serial_line_b_o, .serial_line_b_oe, .host_bus_clock, .command_strobe, .chip_select_n,
		.cmd_qualifier_low, .cmd_qualifier_high, .command_bus, .serial_shift_clock,
		.serial_line_a_i, .serial_line_b_i);
	task chk(input logic [159:0] got, input logic [159:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Single word transfer; waits on hready in both phases
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	// Scroll sum wraps at the row count
	function logic [6:0] scroll_sum(input logic [6:0] v, input logic [6:0] o);
		return 7'((8'(v) + 8'(o)) % 8'd80);
	endfunction
	// Watchdog: the run needs under 20000 cycles
	initial begin
		#3000000;
		bad_count++;
		conclude();
	end
	initial begin
		void'($urandom(63));
		tick(10);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h0, 32'h0, rd);
		chk(rd, 32'h3);
		ahb(1'b1, 32'h4, 32'h7F, rd);
		ahb(1'b0, 32'h10, 32'h0, rd);
		ahb(1'b0, 32'h4, 32'h0, rd);
		chk(rd, 32'h0);
		// Random row with both end bits set, shifted in on line A
		serial_direction <= 1'b1;
		row = 7'($urandom % 80);
		row_v = {5{$urandom}};
		row_v[159] = 1'b1;
		row_v[0] = 1'b1;
		tick(4);
		for (int i = 0; i < 160; i++)
			u_lsc_host_model.shift(row_v[159 - i]);
		chk({serial_line_b_o, serial_line_a_o}, {row_v[159], row_v[0]});
		u_lsc_host_model.cmd(1'b0, 2'b00, row);
		u_lsc_host_model.cmd(1'b0, 2'b11, 7'h04);
		chk({serial_line_b_o, serial_line_a_o}, 2'b00);
		u_lsc_host_model.cmd(1'b0, 2'b01, row);
		for (int i = 0; i < 160; i++) begin
			chk(serial_line_b_o, row_v[159 - i]);
			u_lsc_host_model.shift(1'b0);
		end
		// Upper bits set but ignored; bit0 clears the vector
		u_lsc_host_model.cmd(1'b0, 2'b11, 7'h79);
		vec = 7'h0;
		for (int i = 0; i < 6; i++) begin
			off = (i == 0) ? 7'd79 : 7'($urandom % 80);
			vec = scroll_sum(vec, off);
			u_lsc_host_model.cmd(1'b0, 2'b10, off);
			ahb(1'b0, 32'h4, 32'h0, rd);
			chk(rd[6:0], vec);
		end
		u_lsc_host_model.cmd(1'b1, 2'b10, 7'd5);
		ahb(1'b0, 32'h4, 32'h0, rd);
		chk(rd[6:0], vec);
		// Point the vector at the stored row and fetch it
		u_lsc_host_model.cmd(1'b0, 2'b11, 7'h01);
		u_lsc_host_model.cmd(1'b0, 2'b10, row);
		frame_sync <= 1'b1;
		refresh_clock <= 1'b1;
		tick(8);
		chk(segment_outputs, row_v);
		sync_phase <= 1'b1;
		tick(6);
		chk(segment_outputs, ~row_v);
		ahb(1'b1, 32'h0, 32'h0, rd);
		refresh_clock <= 1'b0;
		tick(5);
		refresh_clock <= 1'b1;
		tick(8);
		chk(segment_outputs, row_v);
		ahb(1'b0, 32'h8, 32'h0, rd);
		chk(rd[6:0], row);
		// Refresh back on: the next rise fetches the counter row, then steps it
		ahb(1'b1, 32'h0, 32'h1, rd);
		refresh_clock <= 1'b0;
		tick(5);
		refresh_clock <= 1'b1;
		tick(8);
		chk(segment_outputs, row_v);
		ahb(1'b0, 32'h8, 32'h0, rd);
		chk(rd[6:0], scroll_sum(row, 7'd1));
		// All four direction and panel pairs; only bit1 may be set in the control word
		for (int i = 0; i < 4; i++) begin
			serial_direction <= i[0];
			u_lsc_host_model.cmd(1'b0, 2'b11, {5'h00, i[1], 1'b0});
			chk({upper_panel_select, serial_line_a_oe}, {i[1], ~(i[0] ^ i[1])});
		end
		// Line B is the input now; the first bit in ends at the line A end
		for (int i = 0; i < 160; i++)
			u_lsc_host_model.shift(row_v[i]);
		// Row beyond the RAM is ignored, so the register keeps its content
		u_lsc_host_model.cmd(1'b0, 2'b01, 7'h7F);
		for (int i = 0; i < 160; i++) begin
			chk(serial_line_a_o, row_v[i]);
			u_lsc_host_model.shift(1'b0);
		end
		display_off <= 1'b1;
		tick(5);
		chk(segment_outputs_oe, 1'b0);
		display_off <= 1'b0;
		tick(5);
		chk(segment_outputs_oe, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire

// *** tb/lsc_host_model.sv ***
// Host model: command bus cycles and serial shifting
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
	input wire logic hclk,
	input wire logic serial_line_a_o,
	input wire logic serial_line_a_oe,
	input wire logic serial_line_b_o,
	input wire logic serial_line_b_oe,
	output logic host_bus_clock,
	output logic command_strobe,
	output logic chip_select_n,
	output logic cmd_qualifier_low,
	output logic cmd_qualifier_high,
	output logic [6:0] command_bus,
	output logic serial_shift_clock,
	output wire logic serial_line_a_i,
	output wire logic serial_line_b_i
);
	// Host bit sits on whichever line the device leaves free
	logic host_bit = 1'b0;
	assign serial_line_a_i = serial_line_a_oe ? serial_line_a_o : host_bit;
	assign serial_line_b_i = serial_line_b_oe ? serial_line_b_o : host_bit;
	initial {host_bus_clock, command_strobe, cmd_qualifier_low, cmd_qualifier_high} = 4'h0;
	initial {chip_select_n, serial_shift_clock, command_bus} = 9'h180;
	task wait_n(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Slow pulse: pins pass two sync flops, so each phase is four cycles
	task pulse;
		wait_n(4);
		host_bus_clock <= 1'b1;
		wait_n(4);
		host_bus_clock <= 1'b0;
		wait_n(4);
	endtask
	// Capture pulse with strobe, then an empty pulse that executes it
	task cmd(input logic cs_n, input logic [1:0] kind, input logic [6:0] d);
		command_strobe <= 1'b1;
		chip_select_n <= cs_n;
		{cmd_qualifier_high, cmd_qualifier_low} <= kind;
		command_bus <= d;
		pulse();
		command_strobe <= 1'b0;
		chip_select_n <= 1'b1;
		command_bus <= ~d;
		pulse();
	endtask
	// Data set before the fall, inverted after the rise
	task shift(input logic b);
		host_bit <= b;
		wait_n(2);
		serial_shift_clock <= 1'b0;
		wait_n(4);
		serial_shift_clock <= 1'b1;
		wait_n(1);
		host_bit <= ~b;
		wait_n(1);
	endtask
endmodule
`default_nettype wire
